// [rtl/drive_speed_profile_generator.sv]
// per-axis speed profile: parameters, commands, ramps, stops and drive pulse output
// assumes: synchronous inputs on clk, avalon-mm master, motor driver taking one-cycle pulses
//
// Our own choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module drive_speed_profile_generator
  import speed_profile_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic ext_halt_in_0,
  input wire logic ext_halt_in_1,
  input wire logic ext_halt_in_2,
  output logic pulse_out,
  output logic dir_out,
  output logic busy_out
);

  // ****************************************
  // helpers
  // ****************************************
  // rate accumulator: carry when the sum reaches one second worth of clocks
  function automatic logic [32:0] acc_step(input logic [31:0] acc, input logic [31:0] inc);
    logic [32:0] s;
    s = {1'b0, acc} + {1'b0, inc};
    if (s >= {1'b0, CLK_HZ_W}) begin
      s = s - {1'b0, CLK_HZ_W};
      if (s >= {1'b0, CLK_HZ_W}) begin
        s = 33'h0;
      end
      acc_step = {1'b1, s[31:0]};
    end else begin
      acc_step = {1'b0, s[31:0]};
    end
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  // ****************************************
  // state
  // ****************************************
  axis_mode_t mode_ff;
  halt_cfg_t incfg_ff;
  logic [SPD_W-1:0] tgt_param_ff, start_ff, step_ff, tgt_ff, speed_ff;
  logic [31:0] accel_ff, decel_ff, goal_ff, mdp_ff, issued_ff, acc_pulses_ff;
  logic [31:0] ramp_acc_ff, phase_ff;
  drive_state_t state_ff;
  logic fixed_ff, dir_ff, stopping_ff, brk_ff, hold_ff, pulse_ff;
  logic wait_ff, busy_ff;
  logic [31:0] rdata_ff;

  drive_state_t nxt_state;
  logic [SPD_W-1:0] nxt_tgt, nxt_speed;
  logic [31:0] nxt_issued, nxt_acc_pulses;
  logic nxt_fixed, nxt_dir, nxt_stopping, nxt_brk, nxt_hold;

  // ****************************************
  // bus decode
  // ****************************************
  wire req = avs_read | avs_write;
  wire wr_commit = avs_write & ~wait_ff;
  wire cmd_go = wr_commit & hit(avs_address, OFS_CMD);
  wire [7:0] cmd = avs_writedata[7:0];
  wire tgt_wr = wr_commit & hit(avs_address, OFS_TARGET);
  wire running = (state_ff != ST_IDLE);
  wire ramped = (tgt_ff > start_ff);
  wire [31:0] remaining = goal_ff - issued_ff;
  wire [SPD_W-1:0] status_speed = speed_ff;
  wire [31:0] status_word = {status_speed, 1'b0, brk_ff, hold_ff, stopping_ff,
                             dir_ff, fixed_ff, state_ff};

  // ****************************************
  // external stop inputs
  // ****************************************
  wire [2:0] halt_raw = {ext_halt_in_2, ext_halt_in_1, ext_halt_in_0};
  wire [2:0] halt_act;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_halt
      assign halt_act[gi] = incfg_ff.enable[gi] & (halt_raw[gi] == incfg_ff.level[gi]);
    end
  endgenerate
  wire halt_hit = |halt_act & running & ~fixed_ff & ~stopping_ff;

  // ****************************************
  // rate and pulse timing
  // ****************************************
  wire ramping = (state_ff == ST_ACCEL) | (state_ff == ST_DECEL);
  wire use_decel = (state_ff == ST_DECEL) & mode_ff.separate_decel_select;
  wire [31:0] rate = use_decel ? decel_ff : accel_ff;
  wire [32:0] ramp_nxt = acc_step(ramp_acc_ff, rate);
  wire ramp_tick = ramping & ramp_nxt[32];
  wire [32:0] phase_nxt = acc_step(phase_ff, {{(32 - SPD_W){1'b0}}, speed_ff});
  wire pulse_tick = running & phase_nxt[32];

  // ****************************************
  // speed change requests
  // ****************************************
  // s-curve ignores a change mid-ramp; an automatic deceleration in progress keeps its course
  wire chg_ok = running & ~stopping_ff & ~(mode_ff.scurve_select & ramping);
  wire [SPD_W-1:0] inc_val = tgt_ff + step_ff;
  wire [SPD_W-1:0] dec_val = (tgt_ff > step_ff) ? (tgt_ff - step_ff) : '0;
  wire spd_inc = cmd_go & (cmd == CMD_SPD_INC);
  wire spd_dec = cmd_go & (cmd == CMD_SPD_DEC);
  wire start_cmd = cmd_go & ~running & (cmd[7:2] == CMD_FIX_POS[7:2]);

  // ****************************************
  // automatic deceleration and triangle prevention
  // ****************************************
  wire auto_pt = mode_ff.manual_decel_select ? (remaining <= mdp_ff)
                                             : (remaining <= acc_pulses_ff);
  wire auto_dec = fixed_ff & ~stopping_ff & ramped & auto_pt;
  wire [31:0] half_goal = {1'b0, goal_ff[31:1]};
  wire [31:0] both_ramps = {acc_pulses_ff[30:0], 1'b0};
  wire tri_hit = (state_ff == ST_ACCEL) & fixed_ff & ~mode_ff.tri_off & ~brk_ff
                 & (both_ramps > half_goal);
  wire last_pulse = fixed_ff & ((remaining == 32'h0) | (pulse_tick & (remaining == 32'h1)));
  wire [SPD_W-1:0] floor_spd = stopping_ff ? start_ff : tgt_ff;

  // ****************************************
  // profile state machine
  // ****************************************
  always_comb begin
    nxt_state = state_ff;
    nxt_tgt = tgt_ff;
    nxt_speed = speed_ff;
    nxt_issued = issued_ff + {31'h0, pulse_tick};
    nxt_acc_pulses = acc_pulses_ff;
    nxt_fixed = fixed_ff;
    nxt_dir = dir_ff;
    nxt_stopping = stopping_ff;
    nxt_brk = brk_ff;
    nxt_hold = hold_ff;
    case (state_ff)
      ST_IDLE: begin
        nxt_issued = 32'h0;
        if (start_cmd) begin
          nxt_fixed = ~cmd[1];
          nxt_dir = cmd[0];
          nxt_tgt = tgt_param_ff;
          nxt_acc_pulses = 32'h0;
          nxt_stopping = 1'b0;
          nxt_brk = 1'b0;
          nxt_hold = 1'b0;
          if (tgt_param_ff > start_ff) begin
            nxt_state = ST_ACCEL;
            nxt_speed = start_ff;
          end else begin
            nxt_state = ST_CONST;
            nxt_speed = tgt_param_ff;
          end
        end
      end
      ST_ACCEL: begin
        nxt_acc_pulses = acc_pulses_ff + {31'h0, pulse_tick};
        if (speed_ff >= tgt_ff) begin
          nxt_speed = tgt_ff;
          nxt_state = ST_CONST;
        end else if (ramp_tick) begin
          nxt_speed = speed_ff + 1'b1;
        end
        if (tri_hit) begin
          nxt_hold = 1'b1;
          nxt_state = ST_CONST;
        end
      end
      ST_CONST: begin
        if (!ramped) begin
          nxt_speed = tgt_ff;
        end else if (speed_ff < tgt_ff && !hold_ff) begin
          nxt_state = ST_ACCEL;
        end else if (speed_ff > tgt_ff) begin
          nxt_state = ST_DECEL;
        end
      end
      ST_DECEL: begin
        if (speed_ff > floor_spd) begin
          if (ramp_tick) begin
            nxt_speed = speed_ff - 1'b1;
          end
        end else if (!stopping_ff) begin
          nxt_speed = tgt_ff;
          nxt_state = ST_CONST;
        end else if (!fixed_ff) begin
          nxt_state = ST_IDLE;
        end else begin
          nxt_speed = start_ff;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    if (running && chg_ok) begin
      if (tgt_wr) begin
        nxt_tgt = avs_writedata[SPD_W-1:0];
      end else if (spd_inc) begin
        nxt_tgt = inc_val;
      end else if (spd_dec) begin
        nxt_tgt = dec_val;
      end
    end
    if (running && auto_dec) begin
      nxt_stopping = 1'b1;
      nxt_state = ST_DECEL;
    end
    if (running && !stopping_ff && (halt_hit || (cmd_go && cmd == CMD_DEC_STOP))) begin
      if (ramped) begin
        nxt_stopping = 1'b1;
        nxt_brk = (state_ff == ST_ACCEL);
        nxt_state = ST_DECEL;
      end else begin
        nxt_state = ST_IDLE;
      end
    end
    if (running && (last_pulse || (cmd_go && cmd == CMD_INST_STOP))) begin
      nxt_state = ST_IDLE;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      tgt_ff <= '0;
      speed_ff <= '0;
      issued_ff <= 32'h0;
      acc_pulses_ff <= 32'h0;
      fixed_ff <= 1'b0;
      dir_ff <= 1'b0;
      stopping_ff <= 1'b0;
      brk_ff <= 1'b0;
      hold_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      tgt_ff <= nxt_tgt;
      speed_ff <= nxt_speed;
      issued_ff <= nxt_issued;
      acc_pulses_ff <= nxt_acc_pulses;
      fixed_ff <= nxt_fixed;
      dir_ff <= nxt_dir;
      stopping_ff <= nxt_stopping;
      brk_ff <= nxt_brk;
      hold_ff <= nxt_hold;
      // taken from the next state so busy lines up with the state register, still a flop
      busy_ff <= (nxt_state != ST_IDLE);
    end
  end

  // accumulators restart with each drive so the first pulse timing is repeatable
  always_ff @(posedge clk) begin
    if (rst || !running) begin
      ramp_acc_ff <= 32'h0;
      phase_ff <= 32'h0;
      pulse_ff <= 1'b0;
    end else begin
      ramp_acc_ff <= ramping ? ramp_nxt[31:0] : 32'h0;
      phase_ff <= phase_nxt[31:0];
      pulse_ff <= pulse_tick & (nxt_state != ST_IDLE | last_pulse);
    end
  end

  // parameter registers; a write lands on the edge where waitrequest is seen low
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_ff <= axis_mode_t'(MODE_RST);
      incfg_ff <= halt_cfg_t'(INCFG_RST);
      tgt_param_ff <= '0;
      start_ff <= '0;
      accel_ff <= 32'h0;
      decel_ff <= 32'h0;
      goal_ff <= 32'h0;
      step_ff <= '0;
      mdp_ff <= 32'h0;
    end else if (wr_commit) begin
      if (hit(avs_address, OFS_MODE)) mode_ff <= axis_mode_t'(avs_writedata[15:0]);
      if (hit(avs_address, OFS_INCFG)) incfg_ff <= halt_cfg_t'(avs_writedata[5:0]);
      if (tgt_wr) tgt_param_ff <= avs_writedata[SPD_W-1:0];
      if (hit(avs_address, OFS_START)) start_ff <= avs_writedata[SPD_W-1:0];
      if (hit(avs_address, OFS_ACCEL)) accel_ff <= avs_writedata;
      if (hit(avs_address, OFS_DECEL)) decel_ff <= avs_writedata;
      if (hit(avs_address, OFS_GOAL)) goal_ff <= avs_writedata;
      if (hit(avs_address, OFS_STEP)) step_ff <= avs_writedata[SPD_W-1:0];
      if (hit(avs_address, OFS_MDPOINT)) mdp_ff <= avs_writedata;
    end
  end

  // ****************************************
  // avalon slave: fixed one wait cycle
  // ****************************************
  wire [31:0] rd_mux =
    hit(avs_address, OFS_MODE) ? {16'h0, mode_ff} :
    hit(avs_address, OFS_INCFG) ? {26'h0, incfg_ff} :
    hit(avs_address, OFS_TARGET) ? {8'h0, tgt_param_ff} :
    hit(avs_address, OFS_START) ? {8'h0, start_ff} :
    hit(avs_address, OFS_ACCEL) ? accel_ff :
    hit(avs_address, OFS_DECEL) ? decel_ff :
    hit(avs_address, OFS_GOAL) ? goal_ff :
    hit(avs_address, OFS_STEP) ? {8'h0, step_ff} :
    hit(avs_address, OFS_MDPOINT) ? mdp_ff :
    hit(avs_address, OFS_STATUS) ? status_word :
    hit(avs_address, OFS_ISSUED) ? issued_ff : 32'h0;

  always_ff @(posedge clk) begin
    if (rst) begin
      wait_ff <= 1'b1;
      rdata_ff <= 32'h0;
    end else begin
      wait_ff <= ~(req & wait_ff);
      if (avs_read && wait_ff) rdata_ff <= rd_mux;
    end
  end

  assign avs_waitrequest = wait_ff;
  assign avs_readdata = rdata_ff;
  assign pulse_out = pulse_ff;
  assign dir_out = dir_ff;
  assign busy_out = busy_ff;

endmodule // drive_speed_profile_generator

// [rtl/speed_profile_pkg.sv]
// package: register map, field layout, command codes, fsm states and timing constants
// assumes: one 50 MHz clock, avalon-mm slave with 32-bit data and byte addresses
package speed_profile_pkg;

  // ****************************************
  // clock and widths
  // ****************************************
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam logic [31:0] CLK_HZ_W = 32'h02fa_f080;
  localparam int SPD_W = 24;
  localparam int ADDR_W = 6;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [ADDR_W-1:0] OFS_MODE = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_INCFG = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_TARGET = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_START = 6'h0c;
  localparam logic [ADDR_W-1:0] OFS_ACCEL = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_DECEL = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_GOAL = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_STEP = 6'h1c;
  localparam logic [ADDR_W-1:0] OFS_MDPOINT = 6'h20;
  localparam logic [ADDR_W-1:0] OFS_CMD = 6'h24;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h28;
  localparam logic [ADDR_W-1:0] OFS_ISSUED = 6'h2c;

  // ****************************************
  // reset values and field positions
  // ****************************************
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [5:0] INCFG_RST = 6'h00;
  localparam int INCFG_LVL_LSB = 3;
  localparam int STAT_SPD_LSB = 8;

  // ****************************************
  // command codes
  // ****************************************
  localparam logic [7:0] CMD_FIX_POS = 8'h50;
  localparam logic [7:0] CMD_FIX_NEG = 8'h51;
  localparam logic [7:0] CMD_CONT_POS = 8'h52;
  localparam logic [7:0] CMD_CONT_NEG = 8'h53;
  localparam logic [7:0] CMD_SPD_INC = 8'h70;
  localparam logic [7:0] CMD_SPD_DEC = 8'h71;
  localparam logic [7:0] CMD_DEC_STOP = 8'h26;
  localparam logic [7:0] CMD_INST_STOP = 8'h27;

  // bit 13 disables triangle prevention; bits 2..0 select the profile
  typedef struct packed {
    logic [1:0] rsv_hi;
    logic tri_off;
    logic [9:0] rsv_mid;
    logic scurve_select;
    logic separate_decel_select;
    logic manual_decel_select;
  } axis_mode_t;

  typedef struct packed {
    logic [2:0] level;
    logic [2:0] enable;
  } halt_cfg_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACCEL = 2'b01,
    ST_CONST = 2'b10,
    ST_DECEL = 2'b11
  } drive_state_t;

endpackage

// [sim/motor_driver_model.sv]
// motor driver model: counts drive pulses into a signed position
// assumes: pulse_out is one clock wide, dir_out high means negative travel
`timescale 1ns/10ps
module motor_driver_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic pulse_out,
  input wire logic dir_out,
  output int pos
);
  // a real driver steps once per pulse edge; one-cycle pulses make level sampling enough
  always_ff @(posedge clk) begin
    if (rst) begin
      pos <= 0;
    end else if (pulse_out) begin
      pos <= dir_out ? pos - 1 : pos + 1;
    end
  end
endmodule // motor_driver_model

// [sim/speed_profile_chk.sv]
// checker: bus handshake, start, stop and pulse relations at the block's ports
// assumes: bound into drive_speed_profile_generator, single clock, synchronous rst
`timescale 1ns/10ps
module speed_profile_chk
  import speed_profile_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic ext_halt_in_0,
  input wire logic ext_halt_in_1,
  input wire logic ext_halt_in_2,
  input wire logic pulse_out,
  input wire logic dir_out,
  input wire logic busy_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire cmd_ok = avs_write && !avs_waitrequest && avs_address == OFS_CMD;
  wire [7:0] code = avs_writedata[7:0];
  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  a_ack_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  a_ack_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("acknowledge without request");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > OFS_ISSUED
    |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
  a_start_fwd: assert property (cmd_ok && code == CMD_CONT_POS && !busy_out
    |=> busy_out && !dir_out) else $error("positive start failed");
  a_start_rev: assert property (cmd_ok && code == CMD_CONT_NEG && !busy_out
    |=> busy_out && dir_out) else $error("negative start failed");
  a_inst_stop: assert property (cmd_ok && code == CMD_INST_STOP |=> !busy_out)
    else $error("instant stop left axis busy");
  a_idle_quiet: assert property (!busy_out && !$past(busy_out) |-> !pulse_out)
    else $error("pulse while idle");
  a_pulse_narrow: assert property (pulse_out |=> !pulse_out)
    else $error("pulse wider than one cycle");
  a_dir_hold: assert property (busy_out && $past(busy_out) |-> $stable(dir_out))
    else $error("direction changed during drive");
  c_cont: cover property (cmd_ok && code == CMD_CONT_NEG);
  c_fixed: cover property (cmd_ok && code == CMD_FIX_POS);
  c_stop: cover property ($fell(busy_out));
endmodule // speed_profile_chk
bind drive_speed_profile_generator speed_profile_chk speed_profile_chk_inst (.clk, .rst,
  .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
  .ext_halt_in_0, .ext_halt_in_1, .ext_halt_in_2, .pulse_out, .dir_out, .busy_out);

// [sim/testbench.sv]
// testbench: avalon master, stop inputs and one task per scenario
// assumes: package, design, checker and driver model compiled first
`timescale 1ns/10ps
module testbench;
  import speed_profile_pkg::*;
  localparam logic [31:0] V0 = 32'h000f_4240;
  localparam logic [31:0] V1 = 32'h000f_4a10;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic halt0 = 1'b0;
  logic halt1 = 1'b0;
  logic halt2 = 1'b0;
  logic pulse_out;
  logic dir_out;
  logic busy_out;
  int pos;
  int n_mismatch = 0;
  int total_checks = 0;
  always #10 clk = ~clk;
  drive_speed_profile_generator drive_speed_profile_generator_inst (.clk, .rst,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .ext_halt_in_0(halt0), .ext_halt_in_1(halt1), .ext_halt_in_2(halt2),
    .pulse_out, .dir_out, .busy_out);
  motor_driver_model motor_driver_model_inst (.clk, .rst, .pulse_out, .dir_out, .pos);
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
      output logic [31:0] q);
    @(posedge clk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask
  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  // polling is unbounded here; the watchdog cuts a hang short
  task automatic wait_st(input logic [1:0] s, output logic [31:0] q);
    do rd(OFS_STATUS, q); while (q[1:0] !== s);
  endtask
  task automatic wait_log(output logic [3:0] seen, output logic [23:0] vmax);
    logic [31:0] q;
    seen = 4'h0;
    vmax = 24'h0;
    do begin
      rd(OFS_STATUS, q);
      seen[q[1:0]] = 1'b1;
      if (q[31:8] > vmax) vmax = q[31:8];
    end while (q[1:0] !== 2'h0);
  endtask
  task automatic setp(input logic [31:0] m, input logic [31:0] s, input logic [31:0] t);
    wr(OFS_MODE, m);
    wr(OFS_START, s);
    wr(OFS_TARGET, t);
    wr(OFS_ACCEL, CLK_HZ_W);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs;
    logic [31:0] q;
    rd(OFS_MODE, q);
    chk(q === 32'h0, "mode reset");
    rd(OFS_INCFG, q);
    chk(q === 32'h0, "input config reset");
    wr(OFS_STEP, 32'hffab_cdef);
    rd(OFS_STEP, q);
    chk(q === 32'h00ab_cdef, "step readback");
    wr(OFS_STATUS, 32'hffff_ffff);
    rd(OFS_STATUS, q);
    chk(q === 32'h0, "status read only");
    rd(6'h30, q);
    chk(q === 32'h0, "unmapped read");
    $display("t_regs done");
  endtask
  task automatic t_const;
    logic [31:0] q;
    int p0;
    setp(32'h0, V0, 32'h0007_a120);
    wr(OFS_INCFG, 32'h09);
    wr(OFS_CMD, CMD_CONT_POS);
    rd(OFS_STATUS, q);
    chk(q[1:0] === 2'h2 && q[31:8] === 24'h07_a120, "constant no ramp");
    p0 = pos;
    repeat (1000) @(posedge clk);
    chk(pos - p0 >= 9 && pos - p0 <= 11, "constant pulse rate");
    halt0 <= 1'b1;
    repeat (4) @(posedge clk);
    chk(busy_out === 1'b0, "halt stops at once");
    halt0 <= 1'b0;
    wr(OFS_INCFG, 32'h0);
    $display("t_const done");
  endtask
  task automatic t_ramp;
    logic [31:0] q;
    int p0;
    setp(32'h2000, V0, V1);
    halt2 <= 1'b1;
    wr(OFS_INCFG, 32'h04);
    wr(OFS_CMD, CMD_CONT_NEG);
    rd(OFS_STATUS, q);
    chk(q[1:0] === 2'h1 && q[31:8] < V1[23:0], "ramp starts low");
    wait_st(2'h2, q);
    chk(q[31:8] === V1[23:0] && dir_out === 1'b1, "ramp reaches target");
    wr(OFS_TARGET, 32'h000f_4628);
    rd(OFS_STATUS, q);
    chk(q[1:0] === 2'h3, "speed write ramps down");
    wait_st(2'h2, q);
    chk(q[31:8] === 24'h0f_4628, "new speed held");
    wr(OFS_STEP, 32'h1f4);
    wr(OFS_CMD, CMD_SPD_INC);
    wait_st(2'h2, q);
    chk(q[31:8] === 24'h0f_481c, "step increase");
    p0 = pos;
    halt2 <= 1'b0;
    repeat (4) @(posedge clk);
    rd(OFS_STATUS, q);
    chk(q[1:0] === 2'h3, "halt decelerates");
    wait_st(2'h0, q);
    chk(pos < p0, "reverse travel");
    halt2 <= 1'b1;
    wr(OFS_INCFG, 32'h0);
    $display("t_ramp done");
  endtask
  task automatic t_fixed(input logic [31:0] m, input logic [31:0] g, input logic tri_on);
    logic [3:0] seen;
    logic [23:0] vmax;
    int p0;
    setp(m, V0, V1);
    wr(OFS_GOAL, g);
    p0 = pos;
    wr(OFS_CMD, CMD_FIX_POS);
    wait_log(seen, vmax);
    chk(seen === 4'hf, "accel hold decel");
    chk((vmax < V1[23:0]) === tri_on, "triangle hold level");
    chk(pos - p0 === int'(g), "all pulses issued");
    $display("t_fixed done");
  endtask
  task automatic t_stop;
    logic [31:0] q;
    int p0;
    setp(32'h0, V0, V1);
    wr(OFS_GOAL, 32'hc8);
    p0 = pos;
    wr(OFS_CMD, CMD_FIX_POS);
    repeat (300) @(posedge clk);
    wr(OFS_CMD, CMD_DEC_STOP);
    rd(OFS_STATUS, q);
    chk(q[1:0] === 2'h3 && q[6] === 1'b1, "stop in accel decelerates");
    chk(q[5] === 1'b0, "no triangle hold");
    wait_st(2'h0, q);
    chk(pos - p0 === 200, "stopped fixed drive ends");
    $display("t_stop done");
  endtask
  task automatic t_scurve;
    logic [31:0] q;
    setp(32'h0004, V0, V1);
    wr(OFS_CMD, CMD_CONT_POS);
    repeat (200) @(posedge clk);
    wr(OFS_TARGET, 32'h000f_4434);
    wait_st(2'h2, q);
    chk(q[31:8] === V1[23:0], "change in accel ignored");
    wr(OFS_CMD, CMD_INST_STOP);
    repeat (2) @(posedge clk);
    chk(busy_out === 1'b0 && pulse_out === 1'b0, "instant stop idles");
    $display("t_scurve done");
  endtask
  task automatic t_dec_halt;
    logic [31:0] q;
    int p0;
    setp(32'h2000, V0, V1);
    wr(OFS_INCFG, 32'h12);
    wr(OFS_STEP, 32'h3e8);
    p0 = pos;
    wr(OFS_CMD, CMD_CONT_POS);
    wait_st(2'h2, q);
    wr(OFS_CMD, CMD_SPD_DEC);
    wait_st(2'h2, q);
    chk(q[31:8] === 24'h0f_4628, "step decrease");
    halt1 <= 1'b1;
    repeat (4) @(posedge clk);
    rd(OFS_STATUS, q);
    chk(q[1:0] === 2'h3, "halt input 1 decelerates");
    wait_st(2'h0, q);
    chk(pos > p0, "forward travel");
    halt1 <= 1'b0;
    wr(OFS_INCFG, 32'h0);
    $display("t_dec_halt done");
  endtask
  task automatic t_manual;
    logic [31:0] q;
    logic [31:0] s1;
    int p0;
    setp(32'h2003, V0, V1);
    wr(OFS_DECEL, 32'h017d_7840);
    wr(OFS_GOAL, 32'h64);
    wr(OFS_MDPOINT, 32'h14);
    p0 = pos;
    wr(OFS_CMD, CMD_FIX_NEG);
    wait_st(2'h3, q);
    s1 = q;
    rd(OFS_ISSUED, q);
    chk(q >= 32'h50 && q <= 32'h51, "manual decel point");
    repeat (200) @(posedge clk);
    rd(OFS_STATUS, q);
    chk(q[1:0] === 2'h3 && (s1[31:8] - q[31:8]) >= 24'h5f && (s1[31:8] - q[31:8]) <= 24'h6e,
        "separate decel rate");
    wait_st(2'h0, q);
    chk(pos - p0 === -100, "negative fixed drive count");
    $display("t_manual done");
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (99000) @(posedge clk);
    n_mismatch++;
    $display("[FAIL] %0t watchdog expired", $time);
    print_verdict();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_const();
    t_ramp();
    t_fixed(32'h2000, 32'h12c, 1'b0);
    t_fixed(32'h0, 32'h28, 1'b1);
    t_stop();
    t_dec_halt();
    t_manual();
    t_scurve();
    print_verdict();
  end
endmodule // testbench
